// >>> verilog/acrcb_pkg.sv
package acrcb_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int ACRCB_NCH = 8;
  localparam int ACRCB_FW = 24;
  localparam int ACRCB_RW = 16;

  // ----------------------------------------------------------------
  // calibration request codes in a channel configuration byte
  // ----------------------------------------------------------------
  localparam logic [1:0] ACRCB_CAL_NONE = 2'h0;
  localparam logic [1:0] ACRCB_CAL_OFS = 2'h1;
  localparam logic [1:0] ACRCB_CAL_POS = 2'h2;
  localparam logic [1:0] ACRCB_CAL_NEG = 2'h3;

  // channel config byte fields
  localparam int ACRCB_CFG_CAL_LSB = 0;
  localparam int ACRCB_CFG_BIP = 2;
  localparam int ACRCB_CFG_PHYS_LSB = 4;

  // ----------------------------------------------------------------
  // reset values of calibration words
  // ----------------------------------------------------------------
  localparam logic [23:0] ACRCB_OFS_RST = 24'h00_0000;
  localparam logic [23:0] ACRCB_GAIN_RST = 24'h80_0000;
  localparam logic [7:0] ACRCB_CFG_RST = 8'h04;

  // ----------------------------------------------------------------
  // clamp codes
  // ----------------------------------------------------------------
  localparam logic [15:0] ACRCB_TOP_TC = 16'h7FFF;
  localparam logic [15:0] ACRCB_TOP_BIN = 16'hFFFF;
  localparam logic [15:0] ACRCB_BOT_TC = 16'h8000;
  localparam logic [15:0] ACRCB_BOT_BIN = 16'h0000;
  localparam logic [15:0] ACRCB_MSB_FLIP = 16'h8000;

  // ----------------------------------------------------------------
  // register map (word index on the plain port)
  // ----------------------------------------------------------------
  localparam logic [5:0] ACRCB_A_CFG = 6'h00;   // 0x00..0x07 config bytes
  localparam logic [5:0] ACRCB_A_CTRL = 6'h08;  // bit0 two's complement, bits 6:4 last active
  localparam logic [5:0] ACRCB_A_STAT = 6'h09;  // bit0 bank sel, bit1 irq, bit2 read started
  localparam logic [5:0] ACRCB_A_RES = 6'h10;   // 0x10..0x17 readable bank
  localparam logic [5:0] ACRCB_A_OFS = 6'h18;   // 0x18..0x1F offset words
  localparam logic [5:0] ACRCB_A_PFS = 6'h20;   // 0x20..0x27 positive gain words
  localparam logic [5:0] ACRCB_A_NFS = 6'h28;   // 0x28..0x2F negative gain words
  localparam logic [7:0] ACRCB_CTRL_RST = 8'h70;

  typedef struct packed {
    logic [5:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } acrcb_bus_s;

  typedef struct packed {
    logic valid;
    logic [2:0] lch;
    logic [23:0] value;
  } acrcb_conv_s;

endpackage

// >>> verilog/acrcb_top.sv
// The register offsets and the strobed register port were decided locally.
module acrcb_top
  import acrcb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // conversions from the filter
  input wire acrcb_conv_s conv,
  // register port
  input wire acrcb_bus_s bus,
  output logic [23:0] rdata,
  // status
  output logic scan_done_irq_n,
  output logic over_range,
  output logic under_range
);

// What this block does
// - positive calibration stores next conversion less offset
// - negative calibration stores negated next conversion less offset
// - calibration done clears channel request
// - over-range when value exceeds positive gain
// - unipolar under-range on sign bit
// - bipolar under-range below negative gain
// - bipolar: ctrl bit0 selects two's complement, else offset binary
// - unipolar always straight binary
// - over-range clamps to top code
// - under-range clamps to bottom code
// - bipolar zero transition at zero scale
// - unipolar full span 0000 to FFFF
// - two read-only banks of eight words
// - one bank writable, other readable
// - reset: bank a writable, irq inactive
// - scan end raises irq, swaps banks
// - host read that completes reading all active results clears irq
// - finished read gives normal swap
// - unstarted read: irq stays, swap
// - partial read: no swap
// - offset calibration stores next conversion
// - default words give uncalibrated results

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] channel_config_byte [ACRCB_NCH];
  logic [23:0] ofs_mem [ACRCB_NCH];
  logic [23:0] pfs_mem [ACRCB_NCH];
  logic [23:0] nfs_mem [ACRCB_NCH];
  logic [15:0] result_bank_a [ACRCB_NCH];
  logic [15:0] result_bank_b [ACRCB_NCH];
  logic [7:0] ctrl;
  logic wr_bank;
  logic read_started;
  logic [ACRCB_NCH-1:0] read_seen;

  // ----------------------------------------------------------------
  // conversion path, one cycle
  // ----------------------------------------------------------------
  logic [1:0] cal_req;
  logic bip;
  logic [2:0] pch;
  logic signed [24:0] corr;
  logic signed [24:0] pgain;
  logic signed [24:0] ngain;
  logic ovr;
  logic und;
  logic [47:0] prod;
  logic [23:0] pdiv;
  logic [23:0] ndiv;
  logic [15:0] mag;
  logic [15:0] scaled;
  logic [15:0] coded;
  logic tc_sel;
  logic last_ch;

  always_comb
  begin
    cal_req = channel_config_byte[conv.lch][ACRCB_CFG_CAL_LSB +: 2];
    bip = channel_config_byte[conv.lch][ACRCB_CFG_BIP];
    pch = channel_config_byte[conv.lch][ACRCB_CFG_PHYS_LSB +: 3];
    tc_sel = ctrl[0];
    last_ch = (conv.lch == ctrl[6:4]);
    // signed offset-corrected value, both operands in two's complement
    corr = $signed({conv.value[23], conv.value}) - $signed({ofs_mem[pch][23], ofs_mem[pch]});
    pgain = $signed({1'b0, pfs_mem[pch]});
    ngain = -$signed({1'b0, nfs_mem[pch]});
    ovr = corr > pgain;
    und = bip ? (corr < ngain) : corr[24];
    // zero gain word would divide by zero
    pdiv = (pfs_mem[pch] == 24'h00_0000) ? 24'h00_0001 : pfs_mem[pch];
    ndiv = (nfs_mem[pch] == 24'h00_0000) ? 24'h00_0001 : nfs_mem[pch];
    // scale so that the gain word maps to full span; 800000 gives unity
    prod = '0;
    mag = '0;
    scaled = '0;
    if (!bip)
    begin
      prod = ({24'h00_0000, corr[23:0]} << 16) / {24'h00_0000, pdiv};
      mag = (prod > 48'h0000_0000_FFFF) ? ACRCB_TOP_BIN : prod[15:0];
      scaled = mag;
    end
    else if (!corr[24])
    begin
      prod = ({24'h00_0000, corr[23:0]} << 15) / {24'h00_0000, pdiv};
      mag = (prod > 48'h0000_0000_7FFF) ? ACRCB_TOP_TC : prod[15:0];
      scaled = mag;
    end
    else
    begin
      // magnitude rounded up so just below zero scale gives all ones
      prod = (({24'h00_0000, 24'(-corr)} << 15) + {24'h00_0000, ndiv} - 48'h0000_0000_0001)
             / {24'h00_0000, ndiv};
      mag = (prod > 48'h0000_0000_8000) ? ACRCB_BOT_TC : prod[15:0];
      scaled = 16'(-mag);
    end
    // coding and clamping
    if (!bip)
      coded = ovr ? ACRCB_TOP_BIN : und ? ACRCB_BOT_BIN : scaled;
    else if (tc_sel)
      coded = ovr ? ACRCB_TOP_TC : und ? ACRCB_BOT_TC : scaled;
    else
      coded = ovr ? ACRCB_TOP_BIN : und ? ACRCB_BOT_BIN : scaled ^ ACRCB_MSB_FLIP;
  end

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  logic res_rd;
  logic [2:0] idx;

  always_comb
  begin
    idx = bus.addr[2:0];
    res_rd = bus.rd && (bus.addr[5:3] == ACRCB_A_RES[5:3]);
  end

  // ----------------------------------------------------------------
  // configuration and calibration memories
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ACRCB_NCH; g++)
    begin : g_ch
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          channel_config_byte[g] <= ACRCB_CFG_RST;
        else if (ce)
        begin
          if (conv.valid && conv.lch == 3'(g) && cal_req != ACRCB_CAL_NONE)
            channel_config_byte[g][ACRCB_CFG_CAL_LSB +: 2] <= ACRCB_CAL_NONE;
          else if (bus.wr && bus.addr == ACRCB_A_CFG + 6'(g))
            channel_config_byte[g] <= bus.wdata[7:0];
        end
      end

      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          ofs_mem[g] <= ACRCB_OFS_RST;
          pfs_mem[g] <= ACRCB_GAIN_RST;
          nfs_mem[g] <= ACRCB_GAIN_RST;
        end
        else if (ce)
        begin
          if (conv.valid && pch == 3'(g) && cal_req == ACRCB_CAL_OFS)
            ofs_mem[g] <= conv.value;
          else if (bus.wr && bus.addr == ACRCB_A_OFS + 6'(g))
            ofs_mem[g] <= bus.wdata;
          if (conv.valid && pch == 3'(g) && cal_req == ACRCB_CAL_POS)
            pfs_mem[g] <= 24'(corr);
          else if (bus.wr && bus.addr == ACRCB_A_PFS + 6'(g))
            pfs_mem[g] <= bus.wdata;
          if (conv.valid && pch == 3'(g) && cal_req == ACRCB_CAL_NEG)
            nfs_mem[g] <= 24'(-corr);
          else if (bus.wr && bus.addr == ACRCB_A_NFS + 6'(g))
            nfs_mem[g] <= bus.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl <= ACRCB_CTRL_RST;
    else if (ce && bus.wr && bus.addr == ACRCB_A_CTRL)
      ctrl <= bus.wdata[7:0];
  end

  // ----------------------------------------------------------------
  // result banks, write side only from conversions
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < ACRCB_NCH; i++)
      begin
        result_bank_a[i] <= '0;
        result_bank_b[i] <= '0;
      end
    end
    else if (ce && conv.valid && cal_req == ACRCB_CAL_NONE)
    begin
      if (!wr_bank)
        result_bank_a[conv.lch] <= coded;
      else
        result_bank_b[conv.lch] <= coded;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      over_range <= 1'b0;
      under_range <= 1'b0;
    end
    else if (ce && conv.valid)
    begin
      over_range <= ovr;
      under_range <= und && !ovr;
    end
  end

  // ----------------------------------------------------------------
  // bank swap and scan-done interrupt
  // ----------------------------------------------------------------
  logic scan_end;
  logic read_done;
  logic [ACRCB_NCH-1:0] next_read_seen;

  always_comb
  begin
    scan_end = conv.valid && last_ch;
    next_read_seen = read_seen;
    if (res_rd)
      next_read_seen[idx] = 1'b1;
    read_done = &(next_read_seen | ~({ACRCB_NCH{1'b1}} >> (3'd7 - ctrl[6:4])));
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_bank <= 1'b0;
      scan_done_irq_n <= 1'b1;
      read_started <= 1'b0;
      read_seen <= '0;
    end
    else if (ce)
    begin
      if (scan_end && !(read_started && !read_done))
      begin
        wr_bank <= !wr_bank;
        scan_done_irq_n <= 1'b0;
        read_started <= 1'b0;
        read_seen <= '0;
      end
      else
      begin
        if (res_rd)
        begin
          read_started <= 1'b1;
          read_seen <= next_read_seen;
        end
        if (res_rd && read_done)
          scan_done_irq_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= '0;
    else if (ce)
    begin
      rdata <= '0;
      if (bus.rd)
      begin
        unique case (bus.addr[5:3])
          3'h0: rdata <= {16'h0000, channel_config_byte[idx]};
          3'h1: rdata <= (idx == 3'h0) ? {16'h0000, ctrl} :
                         (idx == 3'h1) ? {21'h00_0000, read_started, !scan_done_irq_n, wr_bank} : '0;
          3'h2: rdata <= {8'h00, wr_bank ? result_bank_a[idx] : result_bank_b[idx]};
          3'h3: rdata <= ofs_mem[idx];
          3'h4: rdata <= pfs_mem[idx];
          3'h5: rdata <= nfs_mem[idx];
          default: rdata <= '0;
        endcase
      end
    end
  end

endmodule

// >>> tb/acrcb_assertions.sv
module acrcb_assertions
  import acrcb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // design inputs
  input wire acrcb_conv_s conv,
  input wire acrcb_bus_s bus,
  // design outputs
  input wire logic [23:0] rdata,
  input wire logic scan_done_irq_n,
  input wire logic over_range,
  input wire logic under_range
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] last;
  logic scan_end;
  logic res_acc;

  // shadow of the last active channel
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      last <= 3'h7;
    else if (ce && bus.wr && bus.addr == ACRCB_A_CTRL)
      last <= bus.wdata[6:4];
  end

  assign scan_end = ce && conv.valid && conv.lch == last;
  assign res_acc = ce && (bus.rd || bus.wr) && bus.addr >= ACRCB_A_RES;

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_irq_cause: assert property ($fell(scan_done_irq_n) |-> $past(scan_end))
    else $error("irq asserted without scan end");
  a_irq_release: assert property ($rose(scan_done_irq_n) |-> $past(res_acc))
    else $error("irq released without host access");
  a_irq_idle: assert property (scan_done_irq_n && !scan_end |=> scan_done_irq_n)
    else $error("irq left idle without scan end");
  a_flags_hold: assert property (!(ce && conv.valid) |=> $stable(over_range) && $stable(under_range))
    else $error("range flags moved without conversion");
  a_flags_apart: assert property (!(over_range && under_range))
    else $error("over and under range together");
  a_rdata_slot: assert property (rdata != 24'h00_0000 && $past(ce) |-> $past(bus.rd))
    else $error("read data outside its slot");
  a_unmapped_read: assert property ($past(ce && bus.rd && bus.addr >= 6'h30) |-> rdata == 24'h00_0000)
    else $error("unmapped read not zero");
  a_result_narrow: assert property ($past(ce && bus.rd && bus.addr[5:3] == 3'h2) |-> rdata[23:16] == 8'h00)
    else $error("result word wider than 16 bits");
endmodule

bind acrcb_top acrcb_assertions acrcb_assertions_i (.clk(clk), .nrst(nrst), .ce(ce), .conv(conv), .bus(bus),
  .rdata(rdata), .scan_done_irq_n(scan_done_irq_n), .over_range(over_range), .under_range(under_range));

// >>> tb/acrcb_host.sv
module acrcb_host
  import acrcb_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output acrcb_bus_s bus,
  input wire logic [23:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial bus = '0;

  task automatic wr(input logic [5:0] a, input logic [23:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // results are read here; the test also writes ACRCB_A_RES once with wr, and the write is ignored
  task automatic rd(input logic [5:0] a, output logic [23:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 24'h00_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
endmodule

// >>> tb/tb.sv
module tb
  import acrcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic bip;
    logic tc;
    logic [23:0] raw;
    logic [23:0] code;
    logic [1:0] fl;
  } acrcb_row_s;

  logic clk;
  logic nrst;
  logic ce;
  acrcb_conv_s conv;
  acrcb_bus_s bus;
  logic [23:0] rdata;
  logic [23:0] d;
  logic irq_n;
  logic ovr;
  logic und;
  logic s;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  acrcb_row_s rows [11] = '{
    '{1'b1, 1'b1, 24'h00_0010, 24'h00_0000, 2'h0}, '{1'b1, 1'b0, 24'h00_0010, 24'h00_8000, 2'h0},
    '{1'b1, 1'b1, 24'h00_000F, 24'h00_FFFF, 2'h0}, '{1'b1, 1'b0, 24'h00_000F, 24'h00_7FFF, 2'h0},
    '{1'b1, 1'b1, 24'h20_0000, 24'h00_7FFF, 2'h2}, '{1'b1, 1'b0, 24'h20_0000, 24'h00_FFFF, 2'h2},
    '{1'b1, 1'b1, 24'hE0_0000, 24'h00_8000, 2'h1}, '{1'b1, 1'b0, 24'hE0_0000, 24'h00_0000, 2'h1},
    '{1'b0, 1'b1, 24'h20_0000, 24'h00_FFFF, 2'h2}, '{1'b0, 1'b1, 24'h00_000F, 24'h00_0000, 2'h1},
    '{1'b0, 1'b0, 24'h00_0010, 24'h00_0000, 2'h0}};
  logic [23:0] cal_raw [3] = '{24'h00_0010, 24'h10_0010, 24'hF0_0010};
  logic [5:0] cal_addr [3] = '{ACRCB_A_OFS, ACRCB_A_PFS, ACRCB_A_NFS};
  logic [23:0] cal_exp [3] = '{24'h00_0010, 24'h10_0000, 24'h10_0000};

  acrcb_top acrcb_top_i (.clk(clk), .nrst(nrst), .ce(ce), .conv(conv), .bus(bus), .rdata(rdata),
    .scan_done_irq_n(irq_n), .over_range(ovr), .under_range(und));
  acrcb_host acrcb_host_i (.clk(clk), .bus(bus), .rdata(rdata));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [5:0] a, input logic [23:0] exp);
    acrcb_host_i.rd(a, d);
    chk(d, exp);
  endtask

  task automatic cv(input logic [2:0] l, input logic [23:0] v);
    @(posedge clk);
    conv <= '{valid: 1'b1, lch: l, value: v};
    @(posedge clk);
    conv.valid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic final_report();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      final_report();
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    conv = '0;
    repeat (10) @(posedge clk);
    chk({21'h0, irq_n, ovr, und}, 24'h00_0004);
    nrst <= 1'b1;
    rchk(ACRCB_A_STAT, 24'h00_0000);
    rchk(ACRCB_A_OFS, 24'(ACRCB_OFS_RST));
    rchk(ACRCB_A_NFS, 24'(ACRCB_GAIN_RST));
    cv(3'h7, 24'h00_0000);
    chk({23'h0, irq_n}, 24'h00_0000);
    for (int i = 0; i < 8; i++)
      acrcb_host_i.rd(ACRCB_A_RES + 6'(i), d);
    chk(d, 24'h00_8000);
    chk({23'h0, irq_n}, 24'h00_0001);
    for (int i = 0; i < 3; i++)
    begin
      acrcb_host_i.wr(ACRCB_A_CFG, {22'h1, 2'(i + 1)});
      cv(3'h0, cal_raw[i]);
      rchk(ACRCB_A_CFG, 24'h00_0004);
      rchk(cal_addr[i], cal_exp[i]);
    end
    foreach (rows[i])
    begin
      acrcb_host_i.wr(ACRCB_A_CTRL, {23'h0, rows[i].tc});
      acrcb_host_i.wr(ACRCB_A_CFG, {21'h0, rows[i].bip, 2'h0});
      cv(3'h0, rows[i].raw);
      chk({21'h0, irq_n, ovr, und}, {22'h0, rows[i].fl});
      rchk(ACRCB_A_RES, rows[i].code);
      chk({23'h0, irq_n}, 24'h00_0001);
    end
    acrcb_host_i.wr(ACRCB_A_CTRL, 24'h00_0001);
    acrcb_host_i.wr(ACRCB_A_CFG, 24'h00_0004);
    acrcb_host_i.rd(ACRCB_A_STAT, d);
    s = d[0];
    cv(3'h0, 24'h20_0000);
    cv(3'h0, 24'hE0_0000);
    rchk(ACRCB_A_STAT, {21'h0, 2'h1, s});
    acrcb_host_i.wr(ACRCB_A_RES, 24'h00_1234);
    rchk(ACRCB_A_RES, 24'h00_8000);
    acrcb_host_i.wr(ACRCB_A_CTRL, 24'h00_0011);
    acrcb_host_i.rd(ACRCB_A_RES + 6'h1, d);
    cv(3'h0, 24'h00_0010);
    cv(3'h1, 24'h20_0000);
    rchk(ACRCB_A_RES, 24'h00_0000);
    cv(3'h0, 24'hE0_0000);
    cv(3'h1, 24'h00_000F);
    chk({23'h0, irq_n}, 24'h00_0000);
    rchk(ACRCB_A_RES + 6'h1, 24'h00_7FFF);
    chk({23'h0, irq_n}, 24'h00_0001);
    cv(3'h0, 24'h20_0000);
    cv(3'h1, 24'h00_0010);
    rchk(ACRCB_A_RES, 24'h00_7FFF);
    @(posedge clk) ce <= 1'b0;
    cv(3'h0, 24'hE0_0000);
    @(posedge clk) ce <= 1'b1;
    chk({22'h0, ovr, und}, 24'h00_0000);
    rchk(ACRCB_A_RES, 24'h00_7FFF);
    rchk(6'h30, 24'h00_0000);
    final_report();
  end
endmodule
